// *** src/acs_pkg.sv ***
// Constants and types shared by the conversion sequencer
package acs_pkg;

  // Register byte offsets on the APB window
  localparam logic [7:0] OFF_CSR = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_PULLDOWN = 8'h08;
  localparam logic [7:0] OFF_RESULT = 8'h20;

  // Result layout
  localparam int NUM_CHAN = 8;
  localparam int RES_BITS = 10;
  localparam int RES_LSB = 6;
  localparam logic [9:0] SAR_MSB = 10'h200;

  // Values after reset
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] PULLDOWN_RESET = 8'h00;

  // Trigger source encodings; 2'b10 is prohibited and starts nothing
  localparam logic [1:0] TRG_OFF = 2'b00;
  localparam logic [1:0] TRG_TIMER = 2'b01;
  localparam logic [1:0] TRG_EXT = 2'b11;

  // Timing in states (one state is one ref_clk cycle), indexed by clock select
  localparam logic [3:0][9:0] DLY_MIN = {10'd4, 10'd6, 10'd10, 10'd18};
  localparam logic [3:0][9:0] DLY_MAX = {10'd5, 10'd9, 10'd17, 10'd33};
  localparam logic [3:0][9:0] SPL_LEN = {10'd15, 10'd31, 10'd63, 10'd127};
  localparam logic [3:0][9:0] SGL_MIN = {10'd67, 10'd131, 10'd259, 10'd515};
  localparam logic [3:0][9:0] SCAN_TOT = {10'd64, 10'd128, 10'd256, 10'd512};
  localparam logic [9:0] SAR_STEPS = 10'd10;

  // Control status register: end flag, irq enable, start, reserved, channel
  typedef struct packed {
    logic convEndFlag;
    logic endInterruptEnable;
    logic convStartBit;
    logic reserved;
    logic [3:0] chanSel;
  } acs_csr_t;

  // Mode control register
  typedef struct packed {
    logic [1:0] trigSourceSel;
    logic scanModeEnable;
    logic scanGroupSize;
    logic [1:0] convClockSel;
    logic [1:0] reserved;
  } acs_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DELAY = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_CONVERT = 4'b1000
  } acs_state_t;

endpackage

// *** src/acs_sequencer.sv ***
// One converter unit: APB registers, trigger logic and SAR conversion sequencer
`timescale 1ns/1ps
// Operation
// - Ten-bit successive approximation; only single and scan modes exist.
// - Single mode converts the selected channel once when start becomes 1.
// - Single result lands in the converted channel's own result register.
// - Single completion sets end flag; interrupt raised when enable is set.
// - Single start stays 1, self-clears at end; clearing it aborts to wait.
// - Scan groups: mode 10 up to four channels, mode 11 up to eight.
// - Four-channel scan group starts at channel bit 2 times four.
// - Scan starts on software, timer or pin trigger at group's first channel.
// - Scan stores each channel result into its own register in turn.
// - Group end sets flag, interrupts if enabled, restarts at first channel.
// - Scan start never self-clears; clearing it stops to wait state.
// - Restart after a stop begins again at the group's first channel.
// - Start delay, then sampling of 127, 63, 31 or 15 states.
// - Start delay spans 18-19, 10-11, 6-7/14-15 or 4-5 states by write timing.
// - Single conversion totals 515-516, 259-260, 131-132/139-140 or 67-68 states.
// - First scan conversion uses the single-mode variable timing.
// - Later scan conversions take fixed 512, 256, 128 or 64 states.
// - Trigger select 11 sets start on each falling edge of the pin.
// - Pin-started conversions behave exactly like software-started ones.
// - Each unit has its own end interrupt usable by DMA or transfer controller.
// - Per-input pull-down bits reset to 0; writing 1 turns pull-down on.
// - Pull-down bits clear on reset and on software standby entry.
// - Result sits in bits 15..6 of a word; low six bits read 0.
// - End flag clears on 0 written after reading 1, or transfer-controller read.
// - Trigger select: 00 none, 01 timer, 11 pin, 10 prohibited.
module acs_sequencer
  import acs_pkg::*;
(
  // Clock, reset, freeze
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Triggers and system
  input wire logic timerTrigger,
  input wire logic externalTriggerPin_n,
  input wire logic softStandby,
  input wire logic xferActive,
  output logic convEndInterrupt,
  // Analog front end
  input wire logic compIn,
  output logic [2:0] muxSel,
  output logic sampleHold,
  output logic [9:0] dacCode,
  output logic [7:0] pulldownEnable
);

  acs_csr_t csr;
  acs_csr_t next_csr;
  acs_mode_t mode;
  acs_state_t state;
  acs_state_t next_state;
  logic [9:0] result [NUM_CHAN];
  logic [9:0] cnt;
  logic [9:0] next_cnt;
  logic [9:0] stepTimer;
  logic [9:0] sarMask;
  logic [3:0] phase;
  logic firstConv;
  logic readSeen;
  logic extSync1, extSync2, extSync3;
  logic compSync1, compSync2;

  // APB decode
  wire setupPhase = psel & ~penable;
  wire accessDone = psel & penable & pready;
  wire apbWrite = accessDone & pwrite;
  wire apbRead = accessDone & ~pwrite;
  wire hitCsr = paddr == OFF_CSR;
  wire hitMode = paddr == OFF_MODE;
  wire hitPull = paddr == OFF_PULLDOWN;
  wire hitRes = (paddr[7:5] == OFF_RESULT[7:5]) & (paddr[1:0] == 2'b00);
  wire [2:0] resIdx = paddr[4:2];
  wire hitAny = hitCsr | hitMode | hitPull | hitRes;
  wire [7:0] csrView = {csr.convEndFlag, csr.endInterruptEnable, csr.convStartBit,
                        1'b0, csr.chanSel};
  wire [7:0] modeView = {mode[7:2], 2'b00};
  wire [31:0] resView = {16'h0000, result[resIdx], 6'h00};
  wire [31:0] readMux = hitCsr ? {24'h000000, csrView} :
                        hitMode ? {24'h000000, modeView} :
                        hitPull ? {24'h000000, pulldownEnable} :
                        hitRes ? resView : 32'h00000000;

  // Channel group
  wire scanOn = mode.scanModeEnable;
  wire [2:0] firstChan = ~scanOn ? csr.chanSel[2:0] :
                         mode.scanGroupSize ? 3'h0 : {csr.chanSel[2], 2'b00};
  wire [2:0] lastChan = csr.chanSel[2:0];
  wire lastInGroup = muxSel == lastChan;

  // Timing selection
  wire [1:0] cks = mode.convClockSel;
  wire [3:0] dlyJitter = phase & DLY_MAX[cks][3:0] & ~DLY_MIN[cks][3:0];
  wire [9:0] dlyLoad = 10'(DLY_MIN[cks] + {6'h00, dlyJitter} - 10'd2);
  wire [9:0] sglRem = 10'(SGL_MIN[cks] - DLY_MIN[cks] - SPL_LEN[cks]);
  wire [9:0] scanRem = 10'(SCAN_TOT[cks] - SPL_LEN[cks]);
  wire [9:0] remLen = firstConv ? sglRem : scanRem;
  wire [9:0] bitLen = remLen / SAR_STEPS;

  // Events
  wire extFall = extSync3 & ~extSync2;
  wire trigStart = (mode.trigSourceSel == TRG_TIMER & timerTrigger) |
                   (mode.trigSourceSel == TRG_EXT & extFall);
  wire swCsrWrite = apbWrite & hitCsr;
  wire convDone = (state == ST_CONVERT) & (cnt == 10'd0) & csr.convStartBit;
  wire groupEnd = convDone & (~scanOn | lastInGroup);
  wire endFlagClr = (swCsrWrite & ~pwdata[7] & readSeen) |
                    (apbRead & hitRes & xferActive);
  wire sarStep = (state == ST_CONVERT) & (stepTimer == 10'd0) & (sarMask != 10'h000);
  wire [9:0] sarKeep = compSync2 ? dacCode : dacCode & ~sarMask;

  // Start bit, flag and enables; a hardware set beats any clear
  always_comb begin
    next_csr = csr;
    if (swCsrWrite) begin
      next_csr.endInterruptEnable = pwdata[6];
      next_csr.chanSel = pwdata[3:0];
      next_csr.convStartBit = pwdata[5];
    end
    if (convDone & ~scanOn) begin
      next_csr.convStartBit = 1'b0;
    end
    if (trigStart) begin
      next_csr.convStartBit = 1'b1;
    end
    if (swCsrWrite & pwdata[5]) begin
      next_csr.convStartBit = 1'b1;
    end
    if (endFlagClr) begin
      next_csr.convEndFlag = 1'b0;
    end
    if (groupEnd) begin
      next_csr.convEndFlag = 1'b1;
    end
    next_csr.reserved = 1'b0;
  end

  // Sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt - 10'd1;
    case (state)
      ST_IDLE: begin
        next_cnt = dlyLoad;
        if (csr.convStartBit) begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (cnt == 10'd0) begin
          next_state = ST_SAMPLE;
          next_cnt = 10'(SPL_LEN[cks] - 10'd1);
        end
      end
      ST_SAMPLE: begin
        if (cnt == 10'd0) begin
          next_state = ST_CONVERT;
          next_cnt = 10'(remLen - 10'd1);
        end
      end
      ST_CONVERT: begin
        if (cnt == 10'd0 && scanOn) begin
          next_state = ST_SAMPLE;
          next_cnt = 10'(SPL_LEN[cks] - 10'd1);
        end else if (cnt == 10'd0) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (!csr.convStartBit) begin
      next_state = ST_IDLE;
    end
  end

  // Synchronisers for the pin and the comparator
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {extSync1, extSync2, extSync3} <= 3'b111;
      {compSync1, compSync2} <= 2'b00;
    end else if (clkEn) begin
      {extSync1, extSync2, extSync3} <= {externalTriggerPin_n, extSync1, extSync2};
      {compSync1, compSync2} <= {compIn, compSync1};
    end
  end

  // APB answer: one wait-free access phase
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (clkEn) begin
      pready <= setupPhase;
      prdata <= setupPhase & ~pwrite ? readMux : prdata;
      pslverr <= setupPhase & ~hitAny;
    end
  end

  // Registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      csr <= acs_csr_t'(CSR_RESET);
      mode <= acs_mode_t'(MODE_RESET);
      pulldownEnable <= PULLDOWN_RESET;
      readSeen <= 1'b0;
      convEndInterrupt <= 1'b0;
    end else if (clkEn) begin
      csr <= next_csr;
      if (apbWrite & hitMode) begin
        mode <= acs_mode_t'({pwdata[7:2], 2'b00});
      end
      if (softStandby) begin
        pulldownEnable <= PULLDOWN_RESET;
      end else if (apbWrite & hitPull) begin
        pulldownEnable <= pwdata[7:0];
      end
      readSeen <= next_csr.convEndFlag & (readSeen | (apbRead & hitCsr & csr.convEndFlag));
      convEndInterrupt <= csr.convEndFlag & csr.endInterruptEnable;
    end
  end

  // Sequencer state, channel and SAR
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      cnt <= 10'd0;
      phase <= 4'h0;
      firstConv <= 1'b0;
      muxSel <= 3'h0;
      sampleHold <= 1'b0;
      dacCode <= 10'h000;
      sarMask <= 10'h000;
      stepTimer <= 10'd0;
    end else if (clkEn) begin
      state <= next_state;
      cnt <= next_cnt;
      phase <= phase + 4'h1;
      sampleHold <= next_state == ST_SAMPLE;
      if (state == ST_IDLE) begin
        firstConv <= 1'b1;
        muxSel <= firstChan;
      end else if (convDone) begin
        firstConv <= 1'b0;
        muxSel <= lastInGroup ? firstChan : 3'(muxSel + 3'h1);
      end
      if (next_state == ST_CONVERT && state != ST_CONVERT) begin
        dacCode <= SAR_MSB;
        sarMask <= SAR_MSB;
        stepTimer <= 10'(bitLen - 10'd1);
      end else if (sarStep) begin
        dacCode <= sarKeep | (sarMask >> 1);
        sarMask <= sarMask >> 1;
        stepTimer <= 10'(bitLen - 10'd1);
      end else if (state == ST_CONVERT) begin
        stepTimer <= stepTimer - 10'd1;
      end
    end
  end

  // Result registers, one per channel
  for (genvar g = 0; g < NUM_CHAN; g++) begin : gen_result
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        result[g] <= 10'h000;
      end else if (clkEn && convDone && muxSel == 3'(g)) begin
        result[g] <= dacCode;
      end
    end
  end

  // Checking helpers
  logic [9:0] dlyHelp;
  logic [9:0] splHelp;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dlyHelp <= 10'd0;
      splHelp <= 10'd0;
    end else if (clkEn) begin
      dlyHelp <= state == ST_DELAY ? 10'(dlyHelp + 10'd1) : 10'd0;
      splHelp <= state == ST_SAMPLE ? 10'(splHelp + 10'd1) : 10'd0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence seq_pin_fall;
    extSync3 && !extSync2 && mode.trigSourceSel == TRG_EXT && clkEn;
  endsequence
  sequence seq_single_end;
    convDone && !scanOn && clkEn;
  endsequence
  sequence seq_group_end;
    convDone && scanOn && lastInGroup && clkEn;
  endsequence

  chk_result_align: assert property (
    pready && hitRes && !pwrite |-> prdata[5:0] == 6'h00 && prdata[31:16] == 16'h0000)
    else $error("result word has bits outside 15..6");
  chk_single_autoclr: assert property (
    seq_single_end and !trigStart and !(swCsrWrite && pwdata[5])
    |=> !csr.convStartBit && csr.convEndFlag && state == ST_IDLE)
    else $error("single conversion did not self-clear start and set flag");
  chk_abort_wait: assert property (
    state != ST_IDLE && !csr.convStartBit && clkEn |=> state == ST_IDLE)
    else $error("clearing start did not stop conversion");
  chk_irq_gate: assert property (
    $past(clkEn) |-> convEndInterrupt == $past(csr.convEndFlag && csr.endInterruptEnable))
    else $error("interrupt does not follow flag and enable");
  chk_scan_restart: assert property (
    seq_group_end and csr.convStartBit |=> csr.convEndFlag && csr.convStartBit
    && muxSel == $past(firstChan) && state == ST_SAMPLE)
    else $error("scan group end did not flag and restart");
  chk_pin_start: assert property (
    seq_pin_fall |=> csr.convStartBit)
    else $error("pin falling edge did not set start");
  chk_sample_len: assert property (
    state == ST_SAMPLE && cnt == 10'd0 && clkEn |-> splHelp == 10'(SPL_LEN[cks] - 10'd1))
    else $error("sampling window length wrong");
  chk_delay_range: assert property (
    state == ST_DELAY && cnt == 10'd0 && clkEn
    |-> 10'(dlyHelp + 10'd2) >= DLY_MIN[cks] && 10'(dlyHelp + 10'd2) <= DLY_MAX[cks])
    else $error("start delay outside its range");
  chk_pulldown_clr: assert property (
    softStandby && clkEn |=> pulldownEnable == 8'h00)
    else $error("pull-downs not cleared in standby");
  chk_scan_fixed: assert property (
    state == ST_SAMPLE && !firstConv && cnt == 10'd0 && clkEn && csr.convStartBit
    |=> state == ST_CONVERT && cnt == 10'(SCAN_TOT[cks] - SPL_LEN[cks] - 10'd1))
    else $error("later scan conversion not fixed length");

endmodule

// *** tb/acs_sensor_model.sv ***
// Sensor inputs and external trigger source facing one converter unit
`timescale 1ns/1ps
module acs_sensor_model (
  // Clock
  input wire logic ref_clk,
  // Converter side
  input wire logic [2:0] muxSel,
  input wire logic [9:0] dacCode,
  output logic compIn,
  // Trigger source
  input wire logic fire,
  output logic externalTriggerPin_n
);
  logic [2:0] lowCnt = 3'h0;

  // Fixed level per input, distinct so a wrong channel shows
  assign compIn = (10'h05a + 10'(muxSel) * 10'h06b) >= dacCode;

  // Pin idles high; each request is one falling edge and a short low pulse
  always @(posedge ref_clk) begin
    if (fire) lowCnt <= 3'h4;
    else if (lowCnt != 3'h0) lowCnt <= lowCnt - 3'h1;
  end
  assign externalTriggerPin_n = (lowCnt == 3'h0);
endmodule

// *** tb/test_acs_sequencer.sv ***
// Self-checking bench for one converter unit over APB
`timescale 1ns/1ps
module test_acs_sequencer;
  import acs_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic timerTrigger = 1'b0;
  logic softStandby = 1'b0;
  logic xferActive = 1'b0;
  logic fire = 1'b0;
  logic pready, pslverr, convEndInterrupt, compIn, sampleHold, externalTriggerPin_n;
  logic [31:0] prdata;
  logic [2:0] muxSel;
  logic [9:0] dacCode;
  logic [7:0] pulldownEnable;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  int t0;

  acs_sequencer uut (.ref_clk(ref_clk), .reset_n(reset_n), .clkEn(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .timerTrigger(timerTrigger),
    .externalTriggerPin_n(externalTriggerPin_n), .softStandby(softStandby),
    .xferActive(xferActive), .convEndInterrupt(convEndInterrupt), .compIn(compIn),
    .muxSel(muxSel), .sampleHold(sampleHold), .dacCode(dacCode),
    .pulldownEnable(pulldownEnable));

  acs_sensor_model sensor (.ref_clk(ref_clk), .muxSel(muxSel), .dacCode(dacCode),
    .compIn(compIn), .fire(fire), .externalTriggerPin_n(externalTriggerPin_n));

  always #2.5 ref_clk = ~ref_clk;

  // Whole run needs a few thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      final_report;
    end
  end

  task automatic final_report;
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic checkRange(input int got, input int lo, input int hi, input string what);
    compares++;
    if (got < lo || got > hi) begin
      fails++;
      $display("mismatch %0t %s took %0d", $time, what, got);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    checkVal(rd, exp, what);
  endtask

  task automatic waitIrq;
    int n;
    n = 0;
    while (convEndInterrupt !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  function automatic logic [31:0] expRes(input int ch);
    logic [9:0] v;
    v = 10'h05a + 10'(ch) * 10'h06b;
    return {16'h0, v, 6'h00};
  endfunction

  // how: 0 software, 1 timer, 2 pin
  task automatic runSingle(input logic [7:0] mode, input logic [3:0] ch, input int how);
    logic [31:0] c;
    c = {24'h0, 4'h4, ch};
    xfer(1'b1, OFF_CSR, 32'h0);
    xfer(1'b1, OFF_MODE, 32'(mode));
    xfer(1'b1, OFF_CSR, how == 0 ? c | 32'h20 : c);
    if (how == 1) timerTrigger <= 1'b1;
    if (how == 2) fire <= 1'b1;
    @(posedge ref_clk);
    timerTrigger <= 1'b0;
    fire <= 1'b0;
    t0 = cycles;
    waitIrq;
    if (how == 0) checkRange(cycles - t0 - 1, 67, 68, "single time");
    rdChk(OFF_CSR, c | 32'h80, "single end");
    xferActive <= (how == 2);
    rdChk(OFF_RESULT + 8'(4 * ch), expRes(ch), "single result");
    xferActive <= 1'b0;
    if (how != 2) xfer(1'b1, OFF_CSR, c);
    rdChk(OFF_CSR, c, "flag clear");
  endtask

  task automatic runScan(input logic [7:0] mode, input logic [7:0] csr, input int first,
      input int cnt, input int period);
    xfer(1'b1, OFF_CSR, 32'h0);
    xfer(1'b1, OFF_MODE, 32'(mode));
    xfer(1'b1, OFF_CSR, 32'(csr));
    t0 = cycles;
    waitIrq;
    checkRange(cycles - t0 - 2, period - 64 + 67, period - 64 + 68, "scan first");
    t0 = cycles;
    for (int k = 0; k < cnt; k++) begin
      rdChk(OFF_RESULT + 8'(4 * (first + k)), expRes(first + k), "scan result");
    end
    rdChk(OFF_CSR, 32'(csr | 8'h80), "scan flag");
    xfer(1'b1, OFF_CSR, 32'(csr));
    repeat (2) @(posedge ref_clk);
    waitIrq;
    checkRange(cycles - t0, period, period, "scan period");
    rdChk(OFF_CSR, 32'(csr | 8'h80), "scan running");
    xfer(1'b1, OFF_CSR, 32'h40);
    rdChk(OFF_CSR, 32'h40, "scan stop");
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    rdChk(OFF_CSR, 32'(CSR_RESET), "csr reset");
    rdChk(OFF_MODE, 32'(MODE_RESET), "mode reset");
    rdChk(OFF_PULLDOWN, 32'(PULLDOWN_RESET), "pulldown reset");
    xfer(1'b0, 8'h10, 32'h0);
    checkVal({31'h0, err}, 32'h1, "unmapped error");
    checkVal(rd, 32'h0, "unmapped data");
    xfer(1'b1, OFF_MODE, 32'h0f);
    rdChk(OFF_MODE, 32'h0c, "mode reserved");
    xfer(1'b1, OFF_PULLDOWN, 32'ha5);
    rdChk(OFF_PULLDOWN, 32'ha5, "pulldown write");
    checkVal(32'(pulldownEnable), 32'ha5, "pulldown pins");
    softStandby <= 1'b1;
    @(posedge ref_clk);
    softStandby <= 1'b0;
    rdChk(OFF_PULLDOWN, 32'h0, "standby clear");
    runSingle(8'h0c, 4'h3, 0);
    runSingle(8'h4c, 4'h1, 1);
    runSingle(8'hcc, 4'h6, 2);
    // Abort a conversion partway through
    xfer(1'b1, OFF_CSR, 32'h62);
    repeat (20) @(posedge ref_clk);
    xfer(1'b1, OFF_CSR, 32'h42);
    repeat (100) @(posedge ref_clk);
    rdChk(OFF_CSR, 32'h42, "abort");
    xfer(1'b1, OFF_MODE, 32'h8c);
    timerTrigger <= 1'b1;
    fire <= 1'b1;
    @(posedge ref_clk);
    timerTrigger <= 1'b0;
    fire <= 1'b0;
    repeat (100) @(posedge ref_clk);
    rdChk(OFF_CSR, 32'h42, "prohibited select");
    runScan(8'h2c, 8'h67, 4, 4, 256);
    runScan(8'h3c, 8'h67, 0, 8, 512);
    runScan(8'h2c, 8'h63, 0, 4, 256);
    final_report;
  end
endmodule
